/* File: core/signal_modulator.sv */
// Data signal modulator with AXI4-Lite registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "modulator_defines.svh"
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Modulator high uses high carrier, low uses low carrier; output is the selected carrier.
// - Enable bit set mixes inputs; cleared gives no modulated output.
// - Disable forces carriers to pin inputs and modulator to software bit.
// - Select fields keep values while disabled and apply again on enable.
// - Output pin held low whenever the modulated output is disabled.
// - Control 0 bit 5 shows the modulated output registered one clock earlier, read only.
// - Output invert bit inverts the output so it idles high.
// - Software bit is the modulator when the source field selects it or the module is disabled.
// - High carrier invert bit inverts the selected high carrier.
// - Low carrier invert bit inverts the selected low carrier.
// - High sync waits for high carrier falling edge before switching low.
// - Low sync waits for low carrier falling edge before switching high.
// - With sync, the carrier pulse in progress may finish before switching.
// - Carrier codes pick pin, clock, oscillator, reference, captures, PWMs.
// - Modulator codes pick pin, bit, captures, PWMs, comparators, serial.
// - Reserved modulator codes feed a constant zero.
// - All fields reset to zero; unimplemented bits read zero.
// - Module comes up disabled after any reset.
module signal_modulator (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic high_carrier_pin_route,
  input wire logic low_carrier_pin_route,
  input wire logic modulator_pin_route,
  input wire logic internal_fast_oscillator,
  input wire logic reference_clock_out,
  input wire logic capture_unit_one,
  input wire logic capture_unit_two,
  input wire logic pwm_unit_three,
  input wire logic pwm_unit_four,
  input wire logic comparator_one,
  input wire logic comparator_two,
  input wire logic async_serial_unit_rx,
  input wire logic async_serial_unit_tx,
  input wire logic sync_serial_unit_sdo,
  output logic modulated_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] control_0_r;
  logic [7:0] control_1_r;
  logic [7:0] high_carrier_select_r;
  logic [7:0] low_carrier_select_r;
  logic [7:0] modulator_source_select_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic out_seen_r;
  modulator_pkg::carrier_state_t state_r;
  modulator_pkg::carrier_state_t state_nxt;
  logic hi_prev_r;
  logic lo_prev_r;

  logic module_enable;
  logic output_invert;
  logic software_modulation_bit;
  logic high_carrier_invert;
  logic low_carrier_invert;
  logic high_carrier_sync;
  logic low_carrier_sync;
  logic [2:0] high_carrier_choice;
  logic [2:0] low_carrier_choice;
  logic [3:0] modulator_choice;
  logic carrier_hi;
  logic carrier_lo;
  logic modulating_input;
  logic mixed;
  logic do_write;
  logic [7:0] wbyte;

  assign module_enable = control_0_r[`BIT_ENABLE];
  assign output_invert = control_0_r[`BIT_OUT_INVERT];
  assign software_modulation_bit = control_0_r[`BIT_SW_MOD];
  assign high_carrier_invert = control_1_r[`BIT_HI_INVERT];
  assign low_carrier_invert = control_1_r[`BIT_LO_INVERT];
  assign high_carrier_sync = control_1_r[`BIT_HI_SYNC];
  assign low_carrier_sync = control_1_r[`BIT_LO_SYNC];

  ////////////////////////////////////////////////////////////////////////////
  // Source selection
  always_comb begin
    // Disabled forces defaults, registers untouched
    high_carrier_choice = module_enable ?
      high_carrier_select_r[2:0] : 3'h0;
    low_carrier_choice = module_enable ?
      low_carrier_select_r[2:0] : 3'h0;
    modulator_choice = module_enable ?
      modulator_source_select_r[3:0] : 4'h1;
  end

  carrier_mux hi_mux (
    .choice(high_carrier_choice),
    .sources({pwm_unit_four, pwm_unit_three, capture_unit_two,
      capture_unit_one, reference_clock_out, internal_fast_oscillator,
      aclk, high_carrier_pin_route}),
    .invert(high_carrier_invert),
    .carrier(carrier_hi)
  );

  carrier_mux lo_mux (
    .choice(low_carrier_choice),
    .sources({pwm_unit_four, pwm_unit_three, capture_unit_two,
      capture_unit_one, reference_clock_out, internal_fast_oscillator,
      aclk, low_carrier_pin_route}),
    .invert(low_carrier_invert),
    .carrier(carrier_lo)
  );

  always_comb begin
    unique case (modulator_choice)
      4'h0: modulating_input = modulator_pin_route;
      4'h1: modulating_input = software_modulation_bit;
      4'h2: modulating_input = capture_unit_one;
      4'h3: modulating_input = capture_unit_two;
      4'h4: modulating_input = pwm_unit_three;
      4'h5: modulating_input = pwm_unit_four;
      4'h6: modulating_input = comparator_one;
      4'h7: modulating_input = comparator_two;
      4'h8: modulating_input = async_serial_unit_rx;
      4'h9: modulating_input = async_serial_unit_tx;
      4'hA: modulating_input = sync_serial_unit_sdo;
      default: modulating_input = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier synchronisation
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      modulator_pkg::USE_HI: begin
        // With high sync set, leave high only after its pulse falls; without it, at once
        if (!modulating_input &&
            (!high_carrier_sync || (hi_prev_r && !carrier_hi))) begin
          state_nxt = modulator_pkg::USE_LO;
        end
      end
      modulator_pkg::USE_LO: begin
        if (modulating_input &&
            (!low_carrier_sync || (lo_prev_r && !carrier_lo))) begin
          state_nxt = modulator_pkg::USE_HI;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= modulator_pkg::USE_LO;
      hi_prev_r <= 1'b0;
      lo_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hi_prev_r <= carrier_hi;
      lo_prev_r <= carrier_lo;
    end
  end

  always_comb begin
    // Unsynchronised side follows the modulator at once
    if (state_r == modulator_pkg::USE_HI) begin
      if (!modulating_input && !high_carrier_sync) begin
        mixed = carrier_lo;
      end else begin
        mixed = carrier_hi;
      end
    end else begin
      if (modulating_input && !low_carrier_sync) begin
        mixed = carrier_hi;
      end else begin
        mixed = carrier_lo;
      end
    end
    // Polarity, then held low while disabled
    modulated_out = module_enable & (mixed ^ output_invert);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_seen_r <= 1'b0;
    end else begin
      out_seen_r <= modulated_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `OFS_CONTROL_0 || a == `OFS_CONTROL_1 ||
      a == `OFS_HIGH_CARRIER || a == `OFS_LOW_CARRIER ||
      a == `OFS_MOD_SOURCE;
  endfunction

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wbyte = w_data_r[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_0_r <= `RESET_REG;
      control_1_r <= `RESET_REG;
      high_carrier_select_r <= `RESET_REG;
      low_carrier_select_r <= `RESET_REG;
      modulator_source_select_r <= `RESET_REG;
    end else if (do_write && w_strb_r[0]) begin
      unique case (aw_addr_r)
        `OFS_CONTROL_0: control_0_r <= wbyte & `MASK_CONTROL_0;
        `OFS_CONTROL_1: control_1_r <= wbyte & `MASK_CONTROL_1;
        `OFS_HIGH_CARRIER: high_carrier_select_r <= wbyte & `MASK_CARRIER;
        `OFS_LOW_CARRIER: low_carrier_select_r <= wbyte & `MASK_CARRIER;
        `OFS_MOD_SOURCE: modulator_source_select_r <= wbyte & `MASK_SOURCE;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_r <= 32'h0000_0000;
      unique case (s_axi_araddr)
        `OFS_CONTROL_0: begin
          rdata_r[7:0] <= control_0_r;
          rdata_r[`BIT_OUT] <= out_seen_r;
        end
        `OFS_CONTROL_1: rdata_r[7:0] <= control_1_r;
        `OFS_HIGH_CARRIER: rdata_r[7:0] <= high_carrier_select_r;
        `OFS_LOW_CARRIER: rdata_r[7:0] <= low_carrier_select_r;
        `OFS_MOD_SOURCE: rdata_r[7:0] <= modulator_source_select_r;
        default: ;
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  disabled_low_a: assert property (@(posedge aclk)
    disable iff (!aresetn) !module_enable |-> !modulated_out)
    else $error("output not low while disabled");
  sw_source_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !module_enable |-> modulating_input == software_modulation_bit)
    else $error("disabled modulator not software bit");
  status_view_a: assert property (@(posedge aclk)
    disable iff (!aresetn) 1'b1 |=> out_seen_r == $past(modulated_out))
    else $error("status bit stale");
  reserved_zero_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    module_enable && modulator_choice > 4'hA |-> !modulating_input)
    else $error("reserved source not zero");
  hi_sync_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    state_r == modulator_pkg::USE_HI && high_carrier_sync && !hi_prev_r
    |=> state_r == modulator_pkg::USE_HI)
    else $error("left high carrier without falling edge");
  lo_sync_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    state_r == modulator_pkg::USE_LO && low_carrier_sync && !lo_prev_r
    |=> state_r == modulator_pkg::USE_LO)
    else $error("left low carrier without falling edge");
  lo_direct_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !modulating_input && !high_carrier_sync |-> mixed == carrier_lo)
    else $error("low carrier not taken at once");
  hi_direct_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    modulating_input && !low_carrier_sync |-> mixed == carrier_hi)
    else $error("high carrier not taken at once");
  reset_off_a: assert property (@(posedge aclk)
    !aresetn |=> control_0_r == 8'h00)
    else $error("not disabled after reset");
  write_resp_a: assert property (@(posedge aclk)
    disable iff (!aresetn) do_write |=> s_axi_bvalid)
    else $error("write not answered");
endmodule // signal_modulator

/* File: core/modulator_defines.svh */
// Register offsets, field positions and reset values of the signal modulator
`ifndef MODULATOR_DEFINES_SVH
`define MODULATOR_DEFINES_SVH
`define OFS_CONTROL_0 8'h00
`define OFS_CONTROL_1 8'h04
`define OFS_HIGH_CARRIER 8'h08
`define OFS_LOW_CARRIER 8'h0C
`define OFS_MOD_SOURCE 8'h10
`define BIT_ENABLE 7
`define BIT_OUT 5
`define BIT_OUT_INVERT 4
`define BIT_SW_MOD 0
`define BIT_HI_INVERT 5
`define BIT_HI_SYNC 4
`define BIT_LO_INVERT 1
`define BIT_LO_SYNC 0
`define MASK_CONTROL_0 8'h91
`define MASK_CONTROL_1 8'h33
`define MASK_CARRIER 8'h07
`define MASK_SOURCE 8'h0F
`define RESET_REG 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: core/modulator_pkg.sv */
// Types of the signal modulator
package modulator_pkg;
  typedef enum logic [1:0] {
    USE_HI = 2'b01,
    USE_LO = 2'b10
  } carrier_state_t;
endpackage

/* File: core/carrier_mux.sv */
// Carrier source selector with polarity
`timescale 1ns/1ns
module carrier_mux (
  input wire logic [2:0] choice,
  input wire logic [7:0] sources,
  input wire logic invert,
  output logic carrier
);
  always_comb begin
    carrier = sources[choice] ^ invert;
  end
endmodule // carrier_mux

/* File: test/source_model.sv */
// Model of the peripherals and pins that feed the modulator
`timescale 1ns/1ns
module source_model (
  input wire logic [13:0] level,
  output logic modulator_pin_route,
  output logic high_carrier_pin_route,
  output logic low_carrier_pin_route,
  output logic internal_fast_oscillator,
  output logic reference_clock_out,
  output logic capture_unit_one,
  output logic capture_unit_two,
  output logic pwm_unit_three,
  output logic pwm_unit_four,
  output logic comparator_one,
  output logic comparator_two,
  output logic async_serial_unit_rx,
  output logic async_serial_unit_tx,
  output logic sync_serial_unit_sdo
);
  // Levels as commanded, one bit per source
  assign {sync_serial_unit_sdo, async_serial_unit_tx, async_serial_unit_rx,
    comparator_two, comparator_one, pwm_unit_four, pwm_unit_three,
    capture_unit_two, capture_unit_one, reference_clock_out,
    internal_fast_oscillator, low_carrier_pin_route, high_carrier_pin_route,
    modulator_pin_route} = level;
endmodule // source_model

/* File: test/tb_top.sv */
// Self-checking bench for the signal modulator
`timescale 1ns/1ns
`include "modulator_defines.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, modulated_out;
  logic high_carrier_pin_route, low_carrier_pin_route, modulator_pin_route;
  logic internal_fast_oscillator, reference_clock_out, capture_unit_one;
  logic capture_unit_two, pwm_unit_three, pwm_unit_four, comparator_one;
  logic comparator_two, async_serial_unit_rx, async_serial_unit_tx;
  logic sync_serial_unit_sdo;
  logic [13:0] src;
  int n_errors = 0;
  int total_checks = 0;
  int mod_idx [0:10] = '{0, 0, 5, 6, 7, 8, 9, 10, 11, 12, 13};
  ////////////////////////////////////////////////////////////////////////
  signal_modulator dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .high_carrier_pin_route,
    .low_carrier_pin_route, .modulator_pin_route, .internal_fast_oscillator,
    .reference_clock_out, .capture_unit_one, .capture_unit_two,
    .pwm_unit_three, .pwm_unit_four, .comparator_one, .comparator_two,
    .async_serial_unit_rx, .async_serial_unit_tx, .sync_serial_unit_sdo,
    .modulated_out);
  source_model partner (.level(src), .modulator_pin_route,
    .high_carrier_pin_route, .low_carrier_pin_route,
    .internal_fast_oscillator, .reference_clock_out, .capture_unit_one,
    .capture_unit_two, .pwm_unit_three, .pwm_unit_four, .comparator_one,
    .comparator_two, .async_serial_unit_rx, .async_serial_unit_tx,
    .sync_serial_unit_sdo);
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 40) begin
      n_errors++;
      $display("MISMATCH t=%0t write timeout", $time);
    end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, `RESP_OKAY)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 40) begin
      n_errors++;
      $display("MISMATCH t=%0t read timeout", $time);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, {24'h000000, e})
    `CHK(r, `RESP_OKAY)
  endtask
  task automatic setup(input logic [7:0] c0, c1, hc, lc, ms,
                       input logic [13:0] s);
    @(posedge aclk);
    src <= s;
    wr(`OFS_CONTROL_1, c1);
    wr(`OFS_HIGH_CARRIER, hc);
    wr(`OFS_LOW_CARRIER, lc);
    wr(`OFS_MOD_SOURCE, ms);
    wr(`OFS_CONTROL_0, c0);
    @(negedge aclk);
  endtask
  task automatic toggle(input logic [13:0] v0, v1);
    @(posedge aclk);
    src <= v0;
    repeat (2) @(posedge aclk);
    src <= v1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    int c, p, k;
    logic sw;
    logic [13:0] b;
    logic [31:0] d;
    logic [1:0] r;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, aresetn} = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(modulated_out, 1'b0)
    for (c = 0; c < 5; c++) rchk(8'(c * 4), 8'h00);
    rd(8'h14, d, r);
    `CHK(r, `RESP_SLVERR)
    `CHK(d, 32'h00000000)
    $display("test reset done");
    setup(8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 14'h0100);
    `CHK(modulated_out, 1'b1)
    rchk(`OFS_CONTROL_0, 8'hB1);
    rchk(`OFS_CONTROL_1, 8'h33);
    rchk(`OFS_HIGH_CARRIER, 8'h07);
    rchk(`OFS_LOW_CARRIER, 8'h07);
    rchk(`OFS_MOD_SOURCE, 8'h0F);
    $display("test registers done");
    for (p = 0; p < 2; p++) begin
      for (c = 0; c < 16; c++) begin
        b = (c != 1 && c <= 10) ? 14'(1) << mod_idx[c] : 14'h0000;
        sw = (p == 0) == (c == 1);
        setup({7'h40, sw}, 8'h00, 8'h00, 8'h00, 8'(c),
              p == 1 ? (14'h3FE3 & ~b) : (b | 14'h0002));
        `CHK(modulated_out, 1'((p == 0) && (c <= 10)))
      end
    end
    $display("test modulator sources done");
    for (k = 0; k < 8; k++) begin
      if (k != 1) begin
        b = 14'(1) << (k == 0 ? 1 : k + 1);
        setup(8'h81, 8'h00, 8'(k), 8'h00, 8'h01, b);
        `CHK(modulated_out, 1'b1)
        b = 14'(1) << (k == 0 ? 2 : k + 1);
        setup(8'h80, 8'h00, 8'h00, 8'(k), 8'h01, b);
        `CHK(modulated_out, 1'b1)
      end
    end
    setup(8'h81, 8'h20, 8'h00, 8'h00, 8'h01, 14'h0000);
    `CHK(modulated_out, 1'b1)
    setup(8'h80, 8'h02, 8'h00, 8'h00, 8'h01, 14'h0000);
    `CHK(modulated_out, 1'b1)
    setup(8'h90, 8'h02, 8'h00, 8'h00, 8'h01, 14'h0000);
    `CHK(modulated_out, 1'b0)
    $display("test carriers done");
    setup(8'h81, 8'h00, 8'h03, 8'h00, 8'h01, 14'h0010);
    `CHK(modulated_out, 1'b1)
    wr(`OFS_CONTROL_0, 8'h01);
    @(negedge aclk);
    `CHK(modulated_out, 1'b0)
    wr(`OFS_CONTROL_0, 8'h11);
    @(negedge aclk);
    `CHK(modulated_out, 1'b0)
    rchk(`OFS_HIGH_CARRIER, 8'h03);
    rchk(`OFS_MOD_SOURCE, 8'h01);
    wr(`OFS_CONTROL_0, 8'h81);
    @(negedge aclk);
    `CHK(modulated_out, 1'b1)
    rchk(`OFS_CONTROL_0, 8'hA1);
    $display("test enable done");
    setup(8'h81, 8'h10, 8'h00, 8'h00, 8'h01, 14'h0002);
    wr(`OFS_CONTROL_0, 8'h80);
    @(negedge aclk);
    `CHK(modulated_out, 1'b1)
    toggle(14'h0000, 14'h0002);
    `CHK(modulated_out, 1'b0)
    setup(8'h80, 8'h01, 8'h00, 8'h00, 8'h01, 14'h0004);
    wr(`OFS_CONTROL_0, 8'h81);
    @(negedge aclk);
    `CHK(modulated_out, 1'b1)
    toggle(14'h0000, 14'h0004);
    `CHK(modulated_out, 1'b0)
    $display("test sync done");
    wr(`OFS_CONTROL_0, 8'h91);
    @(negedge aclk);
    `CHK(modulated_out, 1'b1)
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(modulated_out, 1'b0)
    rchk(`OFS_CONTROL_0, 8'h00);
    rchk(`OFS_CONTROL_1, 8'h00);
    $display("test reset again done");
    end_of_test();
  end
endmodule // tb_top
